// file: bench/serial_node_model.sv
/* Remote serial node on the receive line: line levels, start bits and bit times.
   Assumes the bench calls its tasks from one process, just after a rising edge. */
`timescale 1ns/1ps
module serial_node_model
(
	input  wire logic pclk,     // Module clock.
	output logic      rxd,      // Line toward the block; it idles high.
	output logic      bit_tick  // One pulse per bit time.
);
	initial rxd = 1'b1;
	initial bit_tick = 1'b0;

	// Change the level, then give the synchroniser time to settle.
	task automatic set_line(input logic v);
		rxd <= v;
		repeat (8) @(posedge pclk);
	endtask

	// One bit time; a tick spaced by three idle cycles.
	task automatic tick();
		bit_tick <= 1'b1;
		@(posedge pclk);
		bit_tick <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	// A low start bit breaks the previous stretch, then n high bit times.
	task automatic run(input int n);
		set_line(1'b0);
		tick();
		set_line(1'b1);
		repeat (n) tick();
	endtask
endmodule

// file: bench/tb.sv
/* Self-checking bench of the serial status flags, reached over APB.
   Assumes the design answers with zero wait states; waits are still open-ended. */
`timescale 1ns/1ps
`include "serial_status_map.svh"
module tb;
	logic                     pclk = 1'b0, presetn = 1'b0;
	logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	serial_status_pkg::addr_t paddr = 8'h00;
	logic [31:0]              pwdata = 32'h0, prdata;
	logic                     pready, rxd, bit_tick, txd, irq, perr, txw;
	logic                     tx_load, tx_queue, bit_check, rx_transfer, break_seen;
	logic [4:0]               ev_v = 5'h00; // Load, queue, check, transfer, break.
	logic                     tx_busy = 1'b0, tx_bit = 1'b1, tx_serial = 1'b1;
	logic [7:0]               rx_data = 8'hA5, tx_data, q;
	int                       err_count = 0, n_compared = 0, cyc = 0;
	localparam logic [7:0]    F = `SSF_OFF_FLAGS, C = `SSF_OFF_CTRL, D = `SSF_OFF_DATA_LOW;

	always #4 pclk = ~pclk;

	// Event pulses fan out to the design's individual strobes.
	always_comb {break_seen, rx_transfer, bit_check, tx_queue, tx_load} = ev_v;
	serial_node_model serial_node_model_inst (.pclk(pclk), .rxd(rxd), .bit_tick(bit_tick));
	serial_status_flags serial_status_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(perr), .rxd(rxd), .bit_tick(bit_tick), .tx_load(tx_load),
		.tx_queue(tx_queue), .tx_busy(tx_busy), .tx_bit(tx_bit), .tx_serial(tx_serial),
		.bit_check(bit_check), .rx_transfer(rx_transfer), .break_seen(break_seen),
		.rx_data(rx_data), .tx_data(tx_data), .tx_write(txw), .txd(txd), .irq(irq));

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// A hang counts as a mismatch and still reaches the verdict.
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(q, e);
	endtask

	// One-cycle event pulse from the transmitter or receiver side.
	task automatic ev(input int k);
		ev_v[k] <= 1'b1;
		@(posedge pclk);
		ev_v <= 5'h00;
	endtask

	task automatic t_tx();
		rd(F, 8'hC0);
		chk(txd, 1'b1);
		rd(8'h10, 8'h00);
		chk(perr, 1'b0);
		wr(F, 8'hFF);
		rd(F, 8'hC0);
		wr(C, 8'h00);
		wr(D, 8'h5A);
		// Data and strobe are flops launched at the access edge; look one edge later.
		@(posedge pclk);
		chk(tx_data, 8'h5A);
		chk(txw, 1'b1);
		rd(F, 8'h00);
		ev(0);
		rd(F, 8'hC0);
		ev_v[1] <= 1'b1;
		rd(F, 8'h80);
		ev_v <= 5'h00;
		tx_busy <= 1'b1;
		tx_serial <= 1'b0;
		rd(F, 8'h80);
		chk(txd, 1'b0);
		tx_busy <= 1'b0;
		tx_serial <= 1'b1;
		wr(`SSF_OFF_IRQ_EN, 8'h80);
		rd(F, 8'hC0);
		chk(irq, 1'b1);
		wr(`SSF_OFF_IRQ_EN, 8'h00);
	endtask

	task automatic t_rx();
		ev(3);
		wr(C, 8'h04);
		serial_node_model_inst.run(10);
		rd(F, 8'hE0);
		serial_node_model_inst.run(11);
		rd(F, 8'hF0);
		rx_data <= 8'h3C;
		rd(D, 8'h3C);
		rd(F, 8'hC0);
		wr(C, 8'h00);
		serial_node_model_inst.run(10);
		rd(F, 8'hC0);
		ev(3);
		wr(C, 8'h08);
		serial_node_model_inst.run(10);
		rd(F, 8'hE0);
		wr(C, 8'h00);
		serial_node_model_inst.run(10);
		rd(F, 8'hF0);
	endtask

	task automatic t_alt();
		wr(C, 8'h01);
		wr(F, 8'hFF);
		rd(F, 8'h00);
		serial_node_model_inst.set_line(1'b0);
		rd(F, 8'h80);
		wr(F, 8'h7F);
		rd(F, 8'h80);
		wr(F, 8'h80);
		rd(F, 8'h00);
		wr(C, 8'h03);
		serial_node_model_inst.set_line(1'b1);
		rd(F, 8'h80);
		wr(C, 8'h11);
		serial_node_model_inst.set_line(1'b0);
		wr(F, 8'hFF);
		ev(2);
		rd(F, 8'h02);
		wr(F, 8'h02);
		tx_bit <= 1'b0;
		serial_node_model_inst.set_line(1'b1);
		ev(2);
		rd(F, 8'h06);
		wr(C, 8'h51);
		rd(C, 8'h51);
		chk(irq, 1'b1);
		wr(C, 8'h21);
		wr(F, 8'h02);
		ev(4);
		apb(1'b0, F, 8'h00);
		chk(q & 8'h83, 8'h01);
		wr(C, 8'hA1);
		rd(C, 8'hA1);
		chk(irq, 1'b1);
		wr(C, 8'h00);
		wr(F, 8'hFF);
		rd(F, 8'hF0);
	endtask

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_tx();
		t_rx();
		t_alt();
		give_verdict();
	end
endmodule

// file: hdl/idle_line_counter.sv
/*
 * Counts consecutive high bit times on the receive line and pulses once when the line is idle.
 * Assumes a one-cycle bit_tick per bit time from the receiver's baud logic on the same clock.
 */
`timescale 1ns/1ps
`include "serial_status_map.svh"
module idle_line_counter
(
	input  wire logic pclk,         // Module clock.
	input  wire logic presetn,      // Asynchronous reset, active low.
	input  wire logic bit_tick,     // One pulse per bit time.
	input  wire logic line_high,    // Filtered receive level.
	input  wire logic ninth_bit,    // Nine-bit frames need one more idle bit.
	output logic      idle_seen     // One-cycle pulse when the idle count is reached.
);
	logic [3:0] ones_r;   // Consecutive high bit times, saturating at the target.
	logic [3:0] target;   // Ones that make an idle line.

	assign target = ninth_bit ? `SSF_IDLE_ONES_9 : `SSF_IDLE_ONES_8;

	// Saturating at the target gives exactly one pulse per idle stretch.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ones_r    <= 4'h0;
			idle_seen <= 1'b0;
		end
		else
		begin
			idle_seen <= bit_tick && line_high && (ones_r == target - 4'h1);
			if (bit_tick)
			begin
				if (!line_high)
				begin
					ones_r <= 4'h0;
				end
				else if (ones_r < target)
				begin
					ones_r <= ones_r + 4'h1;
				end
			end
		end
	end
endmodule

// file: hdl/rx_line_sync.sv
/*
 * Three-stage synchroniser for the receive pin with a two-stage agreement filter and edge pulses.
 * Assumes an asynchronous pin and one clock; the line idles high.
 */
`timescale 1ns/1ps
module rx_line_sync
(
	input  wire logic pclk,     // Module clock.
	input  wire logic presetn,  // Asynchronous reset, active low.
	input  wire logic pin,      // Raw receive pin.
	output logic      level,    // Filtered line level.
	output logic      rise,     // One-cycle pulse on a rising filtered edge.
	output logic      fall      // One-cycle pulse on a falling filtered edge.
);
	logic s1_r;   // First stage, read only by the second.
	logic s2_r;   // Second stage.
	logic s3_r;   // Third stage.

	// Shift the pin through three flops; only s2 looks at s1.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts once the second and third stages agree, which rejects a one-cycle glitch.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			level <= 1'b1;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end
		else
		begin
			rise  <= (s2_r == s3_r) && s3_r && !level;
			fall  <= (s2_r == s3_r) && !s3_r && level;
			if (s2_r == s3_r)
			begin
				level <= s3_r;
			end
		end
	end
endmodule

// file: hdl/serial_status_flags.sv
/*
 * Status-flag logic of an asynchronous serial interface, reached as an APB slave.
 * Assumes the transmitter, receiver and baud logic outside run on pclk and report their events
 * as one-cycle pulses; only the receive pin is asynchronous.
 */
// Operation
// R01: Receive edge flag on polarity-selected active edge.
// R02: Alternate flags clear only by writing one.
// R03: Bit-error value records sampled receive level.
// R04: Mismatch sets bit-error flag, optional interrupt.
// R05: Received break sets break flag, optional interrupt.
// R06: Alternate flags reachable only when alternate selected.
// R07: Writes to main flags change nothing.
// R08: Status read then data access clears.
// R09: Shift register load sets transmit empty.
// R10: Status read, data write clears empty.
// R11: Done low while sending, high when idle.
// R12: Done holds transmit output at one.
// R13: Done clears by sequence or on queueing.
// R14: Simultaneous set and clear leaves done cleared.
// R15: Receive transfer sets full; sequence read clears.
// R16: Ten or eleven ones set idle flag.
// R17: After clear, idle waits for receive full.
// R18: Status read, data read clears idle.
// R19: Sleeping receiver never sets idle flag.
// R20: Enabled flags ORed onto one interrupt.
// R21: Reset clears events, transmitter shows idle.
`timescale 1ns/1ps
`include "serial_status_map.svh"
module serial_status_flags
(
	input  wire logic                        pclk,        // APB clock, 125 MHz.
	input  wire logic                        presetn,     // Asynchronous reset, active low.
	input  wire logic                        psel,        // APB select.
	input  wire logic                        penable,     // APB access phase.
	input  wire logic                        pwrite,      // APB direction, high for write.
	input  wire serial_status_pkg::addr_t    paddr,       // APB byte address.
	input  wire logic [31:0]                 pwdata,      // APB write data.
	output logic [31:0]                      prdata,      // APB read data.
	output logic                             pready,      // APB ready.
	output logic                             pslverr,     // APB error, never raised.
	input  wire logic                        rxd,         // Receive pin.
	input  wire logic                        bit_tick,    // One pulse per receive bit time.
	input  wire logic                        tx_load,     // Shift register took a byte.
	input  wire logic                        tx_queue,    // Data, preamble or break queued.
	input  wire logic                        tx_busy,     // Transmitter is shifting.
	input  wire logic                        tx_bit,      // Level being transmitted.
	input  wire logic                        tx_serial,   // Serial bit from the shifter.
	input  wire logic                        bit_check,   // Sample strobe for bit-error check.
	input  wire logic                        rx_transfer, // Receive data moved to data register.
	input  wire logic                        break_seen,  // Receiver found a break.
	input  wire logic [7:0]                  rx_data,     // Received byte.
	output logic [7:0]                       tx_data,     // Byte written to data low.
	output logic                             tx_write,    // Pulse on a data low write.
	output logic                             txd,         // Transmit pin.
	output logic                             irq          // Interrupt request, active high.
);
	serial_status_pkg::ctrl_s ctrl_r;   // Control register.
	logic [7:0]  irq_en_r;              // Per-flag interrupt enables for the main flags, bit 3 for the receive edge flag.
	logic        tx_empty_flag;         // Transmit data register empty.
	logic        tx_done_flag;          // No transmission in progress.
	logic        rx_full_flag;          // Received byte waiting.
	logic        idle_flag;             // Receive line went idle.
	logic        idle_allow_r;          // A frame arrived since idle was last cleared.
	logic        rx_edge_flag;          // Active receive edge seen.
	logic        bit_error_flag;        // Receive level differed from transmit level.
	logic        bit_error_value;       // Level sampled at the mismatch.
	logic        break_detect_flag;     // Break received.
	logic        arm_te_r;              // Status read saw transmit empty.
	logic        arm_tc_r;              // Status read saw transmit done.
	logic        arm_rf_r;              // Status read saw receive full.
	logic        arm_id_r;              // Status read saw idle.
	logic [7:0]  main_flags;            // Main flag register image.
	logic [7:0]  alt_flags;             // Alternate flag register image.
	logic [7:0]  rd_mux;                // Read value chosen in the setup cycle.
	logic        access;                // Access phase, the transfer completes now.
	logic        wr;                    // Write completes this cycle.
	logic        rd;                    // Read completes this cycle.
	logic        at_flags;              // Offset zero is addressed.
	logic        main_rd;               // Main flag register is read.
	logic        alt_wr;                // Alternate flag register is written.
	logic        dl_wr;                 // Data low is written.
	logic        dl_rd;                 // Data low is read.
	logic        rx_level;              // Filtered receive level.
	logic        rx_rise;               // Rising receive edge.
	logic        rx_fall;               // Falling receive edge.
	logic        idle_seen;             // Idle line found.
	logic        mismatch;              // Bit-error condition this cycle.
	logic        tc_set;                // Transmit done set condition.
	logic        tc_clear;              // Transmit done clear condition.

	// Receive pin synchroniser and idle counter.
	rx_line_sync u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (rxd),
		.level   (rx_level),
		.rise    (rx_rise),
		.fall    (rx_fall)
	);

	idle_line_counter u_idle
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.bit_tick  (bit_tick),
		.line_high (rx_level),
		.ninth_bit (ctrl_r.ninth_bit_select),
		.idle_seen (idle_seen)
	);

	// The slave answers in the first access cycle; read data was latched during setup.
	assign access   = psel && penable;
	assign pready   = access;
	assign pslverr  = 1'b0;
	assign wr       = access && pwrite;
	assign rd       = access && !pwrite;
	assign at_flags = (paddr == `SSF_OFF_FLAGS);
	assign main_rd  = rd && at_flags && !ctrl_r.alt_register_select;     // [R06]
	assign alt_wr   = wr && at_flags && ctrl_r.alt_register_select;      // [R06]
	assign dl_wr    = wr && (paddr == `SSF_OFF_DATA_LOW);
	assign dl_rd    = rd && (paddr == `SSF_OFF_DATA_LOW);
	assign mismatch = ctrl_r.bit_error_check_en && bit_check && (rx_level != tx_bit);

	// Register images; bits without a flag read as zero.
	always_comb
	begin
		main_flags = 8'h00;
		main_flags[`SSF_TX_EMPTY_BIT] = tx_empty_flag;
		main_flags[`SSF_TX_DONE_BIT]  = tx_done_flag;
		main_flags[`SSF_RX_FULL_BIT]  = rx_full_flag;
		main_flags[`SSF_IDLE_BIT]     = idle_flag;
		alt_flags = 8'h00;
		alt_flags[`SSF_RX_EDGE_BIT]   = rx_edge_flag;
		alt_flags[`SSF_BERR_VAL_BIT]  = bit_error_value;
		alt_flags[`SSF_BERR_BIT]      = bit_error_flag;
		alt_flags[`SSF_BREAK_BIT]     = break_detect_flag;
	end

	// Read decode; offset zero shows the alternate flags only while they are selected.
	always_comb
	begin
		case (paddr)
			`SSF_OFF_FLAGS:    rd_mux = ctrl_r.alt_register_select ? alt_flags : main_flags; // [R06]
			`SSF_OFF_CTRL:     rd_mux = ctrl_r;
			`SSF_OFF_DATA_LOW: rd_mux = rx_data;
			`SSF_OFF_IRQ_EN:   rd_mux = irq_en_r;
			default:           rd_mux = 8'h00;
		endcase
	end

	// Latching read data in setup keeps prdata a flop and fixes what the status read observed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (psel && !penable)
		begin
			prdata <= {24'h00_0000, rd_mux};
		end
	end

	// Control and enable registers; a write to the main flags falls to no branch here.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r   <= `SSF_CTRL_RESET;
			irq_en_r <= `SSF_IRQ_EN_RESET;
		end
		else if (wr && paddr == `SSF_OFF_CTRL)                                 // [R07]
		begin
			ctrl_r <= pwdata[7:0];
		end
		else if (wr && paddr == `SSF_OFF_IRQ_EN)
		begin
			irq_en_r <= pwdata[7:0] & 8'hF8;
		end
	end

	// Transmit data path towards the shifter.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_data  <= 8'h00;
			tx_write <= 1'b0;
		end
		else
		begin
			tx_write <= dl_wr;
			if (dl_wr)
			begin
				tx_data <= pwdata[7:0];
			end
		end
	end

	// Arms remember that a status read saw the flag set; unrelated accesses in between leave
	// them alone, and the data access that completes the sequence disarms them.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			arm_te_r <= 1'b0;
			arm_tc_r <= 1'b0;
			arm_rf_r <= 1'b0;
			arm_id_r <= 1'b0;
		end
		else
		begin
			if (main_rd)
			begin
				arm_te_r <= prdata[`SSF_TX_EMPTY_BIT] || (arm_te_r && !dl_wr); // [R08]
				arm_tc_r <= prdata[`SSF_TX_DONE_BIT] || (arm_tc_r && !dl_wr);  // [R08]
				arm_rf_r <= prdata[`SSF_RX_FULL_BIT] || (arm_rf_r && !dl_rd);  // [R08]
				arm_id_r <= prdata[`SSF_IDLE_BIT] || (arm_id_r && !dl_rd);     // [R08]
			end
			else
			begin
				arm_te_r <= arm_te_r && !dl_wr;
				arm_tc_r <= arm_tc_r && !dl_wr;
				arm_rf_r <= arm_rf_r && !dl_rd;
				arm_id_r <= arm_id_r && !dl_rd;
			end
		end
	end

	// Transmit empty; a load in the clearing cycle wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_empty_flag <= 1'b1;                                             // [R21]
		end
		else if (tx_load)
		begin
			tx_empty_flag <= 1'b1;                                             // [R09]
		end
		else if (dl_wr && arm_te_r)
		begin
			tx_empty_flag <= 1'b0;                                             // [R10]
		end
	end

	// Transmit done; here the clear beats the set, so a collision reads as still sending.
	assign tc_set   = tx_empty_flag && !tx_busy;                           // [R11]
	assign tc_clear = (dl_wr && arm_tc_r) || tx_queue;                     // [R13]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_done_flag <= 1'b1;                                              // [R21]
		end
		else if (tc_clear || tx_busy)
		begin
			tx_done_flag <= 1'b0;                                              // [R14]
		end
		else if (tc_set)
		begin
			tx_done_flag <= 1'b1;                                              // [R11]
		end
	end

	// Transmit pin is idle high from the cycle after transmit done is set.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txd <= 1'b1;
		end
		else
		begin
			txd <= tx_done_flag ? 1'b1 : tx_serial;                            // [R12]
		end
	end

	// Receive full; a new transfer in the clearing cycle wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_full_flag <= 1'b0;
		end
		else if (rx_transfer)
		begin
			rx_full_flag <= 1'b1;                                              // [R15]
		end
		else if (dl_rd && arm_rf_r)
		begin
			rx_full_flag <= 1'b0;                                              // [R15]
		end
	end

	// Idle permission: given by a received frame, withdrawn by the idle clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_allow_r <= 1'b0;
		end
		else if (rx_transfer)
		begin
			idle_allow_r <= 1'b1;                                              // [R17]
		end
		else if (dl_rd && arm_id_r && idle_flag)
		begin
			idle_allow_r <= 1'b0;                                              // [R17]
		end
	end

	// Idle flag; a sleeping receiver ignores idle lines.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_flag <= 1'b0;
		end
		else if (idle_seen && idle_allow_r && !ctrl_r.receiver_sleep)
		begin
			idle_flag <= 1'b1;                                                 // [R16] [R19]
		end
		else if (dl_rd && arm_id_r)
		begin
			idle_flag <= 1'b0;                                                 // [R18]
		end
	end

	// Alternate flags; only a one written with the alternate map selected clears, and a new
	// event in the clearing cycle wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_edge_flag      <= 1'b0;
			bit_error_flag    <= 1'b0;
			break_detect_flag <= 1'b0;
		end
		else
		begin
			if (ctrl_r.receive_polarity ? rx_rise : rx_fall)
			begin
				rx_edge_flag <= 1'b1;                                          // [R01]
			end
			else if (alt_wr && pwdata[`SSF_RX_EDGE_BIT])
			begin
				rx_edge_flag <= 1'b0;                                          // [R02]
			end
			if (mismatch)
			begin
				bit_error_flag <= 1'b1;                                        // [R04]
			end
			else if (alt_wr && pwdata[`SSF_BERR_BIT])
			begin
				bit_error_flag <= 1'b0;                                        // [R02]
			end
			if (ctrl_r.break_detect_enable && break_seen)
			begin
				break_detect_flag <= 1'b1;                                     // [R05]
			end
			else if (alt_wr && pwdata[`SSF_BREAK_BIT])
			begin
				break_detect_flag <= 1'b0;                                     // [R02]
			end
		end
	end

	// Bit-error value follows the latest mismatch; meaningless while the flag is clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_error_value <= 1'b0;                                           // [R21]
		end
		else if (mismatch)
		begin
			bit_error_value <= rx_level;                                       // [R03]
		end
	end

	// One interrupt line for every enabled flag.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(main_flags & irq_en_r)                                    // [R20]
				|| (rx_edge_flag && irq_en_r[3])
				|| (bit_error_flag && ctrl_r.bit_error_irq_enable)
				|| (break_detect_flag && ctrl_r.break_irq_enable);
		end
	end

	property p_edge;
		@(posedge pclk) disable iff (!presetn)
		(rx_fall && !ctrl_r.receive_polarity) |=> rx_edge_flag;
	endproperty
	a_edge: assert property (p_edge) else $error("active edge did not set flag"); // [R01]

	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
		$fell(bit_error_flag) |-> $past(alt_wr && pwdata[`SSF_BERR_BIT]);
	endproperty
	a_w1c: assert property (p_w1c) else $error("bit-error flag fell without write"); // [R02]

	property p_berr;
		@(posedge pclk) disable iff (!presetn)
		mismatch |=> (bit_error_flag && bit_error_value == $past(rx_level));
	endproperty
	a_berr: assert property (p_berr) else $error("mismatch not recorded"); // [R03] [R04]

	property p_break;
		@(posedge pclk) disable iff (!presetn)
		(break_seen && ctrl_r.break_detect_enable) |=> break_detect_flag ##1 break_detect_flag;
	endproperty
	a_break: assert property (p_break) else $error("break flag not held"); // [R05]

	property p_altmap;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && at_flags && !ctrl_r.alt_register_select)
			|=> prdata[7:0] == $past(main_flags);
	endproperty
	a_altmap: assert property (p_altmap) else $error("offset zero not main flags"); // [R06]

	property p_tc_clear;
		@(posedge pclk) disable iff (!presetn)
		tx_queue |=> !tx_done_flag;
	endproperty
	a_tc_clear: assert property (p_tc_clear) else $error("done survived queueing"); // [R13] [R14]

	property p_txd_idle;
		@(posedge pclk) disable iff (!presetn)
		tx_done_flag |=> txd;
	endproperty
	a_txd_idle: assert property (p_txd_idle) else $error("transmit pin not idle"); // [R12]

	property p_sleep;
		@(posedge pclk) disable iff (!presetn)
		(!idle_flag && ctrl_r.receiver_sleep) |=> !idle_flag;
	endproperty
	a_sleep: assert property (p_sleep) else $error("idle set while asleep"); // [R19]

	property p_te_clear;
		@(posedge pclk) disable iff (!presetn)
		$fell(tx_empty_flag) |-> $past(dl_wr && arm_te_r);
	endproperty
	a_te_clear: assert property (p_te_clear) else $error("empty cleared out of sequence"); // [R10]
endmodule

// file: hdl/serial_status_map.svh
/*
 * Register offsets, field positions, reset values and counts of the serial status-flag block.
 * Assumes that it is included by bare name from the modules, and nothing else.
 */
`ifndef SERIAL_STATUS_MAP_SVH
`define SERIAL_STATUS_MAP_SVH

// Byte addresses on the APB; each register takes one aligned 32-bit word.
`define SSF_OFF_FLAGS      8'h00
`define SSF_OFF_CTRL       8'h04
`define SSF_OFF_DATA_LOW   8'h08
`define SSF_OFF_IRQ_EN     8'h0C

// Main flag register fields.
`define SSF_TX_EMPTY_BIT   7
`define SSF_TX_DONE_BIT    6
`define SSF_RX_FULL_BIT    5
`define SSF_IDLE_BIT       4

// Alternate flag register fields.
`define SSF_RX_EDGE_BIT    7
`define SSF_BERR_VAL_BIT   2
`define SSF_BERR_BIT       1
`define SSF_BREAK_BIT      0

// Reset values: an idle transmitter shows empty and done, everything else is clear.
`define SSF_MAIN_RESET     8'hC0
`define SSF_ALT_RESET      8'h00
`define SSF_CTRL_RESET     8'h00
`define SSF_IRQ_EN_RESET   8'h00

// Consecutive ones that make an idle line, for eight-bit and nine-bit frames.
`define SSF_IDLE_ONES_8    4'hA
`define SSF_IDLE_ONES_9    4'hB

`endif

// file: hdl/serial_status_pkg.sv
/*
 * Types shared by the serial status-flag block: the control register layout and the address type.
 * Assumes that the offsets and counts come from serial_status_map.svh.
 */
package serial_status_pkg;

	// Bus address as the block decodes it.
	typedef logic [7:0] addr_t;

	// Control register, most significant field first.
	typedef struct packed {
		logic break_irq_enable;     // Break flag may raise the interrupt.
		logic bit_error_irq_enable; // Bit-error flag may raise the interrupt.
		logic break_detect_enable;  // Break detection is armed.
		logic bit_error_check_en;   // Receive level is compared with transmit level.
		logic receiver_sleep;       // Receiver is asleep; idle lines are ignored.
		logic ninth_bit_select;     // Frames carry nine data bits.
		logic receive_polarity;     // Rising receive edge is the active edge when high.
		logic alt_register_select;  // Offset zero shows the alternate flags.
	} ctrl_s;

endpackage
